// File: common/fcc_pkg.sv
// shared constants for the flag invert / compare datapath
package fcc_pkg;

	// apb register byte offsets
	localparam int FCC_ADDR_W = 8;
	localparam logic [7:0] FCC_OFS_INSTR = 8'h00;
	localparam logic [7:0] FCC_OFS_FLAGS = 8'h04;
	localparam logic [7:0] FCC_OFS_DST = 8'h08;
	localparam logic [7:0] FCC_OFS_SRC = 8'h0C;
	localparam logic [7:0] FCC_OFS_CMP = 8'h10;
	localparam logic [7:0] FCC_OFS_STATUS = 8'h14;

	// reset values
	localparam logic [7:0] FCC_FLAGS_RST = 8'h00;
	localparam logic [31:0] FCC_WORD_RST = 32'h0000_0000;
	localparam logic [15:0] FCC_INSTR_RST = 16'h0000;

	// flag invert instruction word: pattern and mask field
	localparam logic [7:0] FCC_INV_HI = 8'h8D;
	localparam logic [3:0] FCC_INV_LO = 4'h5;
	localparam int FCC_INSTR_W = 16;
	localparam int FCC_MASK_LSB = 4;
	localparam int FCC_MASK_W = 4;

	// flag register bit positions
	localparam int FCC_FLAGS_W = 8;
	localparam int FCC_FLG_C = 7;
	localparam int FCC_FLG_Z = 6;
	localparam int FCC_FLG_S = 5;
	localparam int FCC_FLG_PV = 4;
	localparam int FCC_FLG_D = 3;
	localparam int FCC_FLG_H = 2;

	// compare command field positions
	localparam int FCC_CMD_SIZE_LSB = 0;
	localparam int FCC_CMD_VAR_BIT = 2;
	localparam int FCC_CMD_MODE_LSB = 3;

	// operand widths of the three compare forms
	localparam int FCC_BYTE_W = 8;
	localparam int FCC_WORD_W = 16;
	localparam int FCC_LONG_W = 32;

	// pending operation
	typedef enum logic [1:0] {
		FCC_OP_IDLE = 2'b00,
		FCC_OP_INVERT = 2'b01,
		FCC_OP_CMP = 2'b10
	} fcc_op_e;

	// compare operand size
	typedef enum logic [1:0] {
		FCC_SZ_BYTE = 2'b00,
		FCC_SZ_WORD = 2'b01,
		FCC_SZ_LONG = 2'b10
	} fcc_size_e;

	// addressing mode of the operand named by the variant
	typedef enum logic [1:0] {
		FCC_MD_REG = 2'b00,
		FCC_MD_IMM = 2'b01,
		FCC_MD_IND = 2'b10,
		FCC_MD_EXT = 2'b11
	} fcc_mode_e;

endpackage

// File: hw/fcc_cmp.sv
`timescale 1ns/10ps
// destination minus source at one width, flags only
module fcc_cmp #(
	parameter int W = 8
) (
	// operands
	input wire logic [W-1:0] dst,
	input wire logic [W-1:0] src,
	// resulting flags
	output logic borrow,
	output logic zero,
	output logic sign,
	output logic ovf
);
	logic [W:0] sum;

	// two's complement of the source added to the destination
	assign sum = {1'b0, dst} + {1'b0, ~src} + {{W{1'b0}}, 1'b1};
	assign borrow = ~sum[W];
	assign zero = (sum[W-1:0] == '0);
	assign sign = sum[W-1];
	// operand signs differ and result sign departs from destination
	assign ovf = (dst[W-1] != src[W-1]) && (sum[W-1] != dst[W-1]);
endmodule // fcc_cmp

// File: hw/fcc_top.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
// Behaviour
// - flag invert flips each of C, Z, S, P/V whose mask bit is one
// - invert word: high byte 8D, low nibble 5, bits 7:4 xor onto flags 7:4
// - invert touches no other flag bit, D and H included; no exception
// - parity and overflow are one shared flag bit
// - compare adds the source's two's complement to the destination
// - compare keeps both operands, writes no result, only sets flags
// - register compare: register destination, source by any of four modes
// - immediate compare: indirect or extended destination, immediate source
// - zero set on zero difference, sign set on negative difference
// - overflow set on signed overflow of the subtraction
// - carry cleared on carry out of top bit, set on borrow
module fcc_top
	import fcc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [FCC_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// flag register and completion towards the core
	output logic [FCC_FLAGS_W-1:0] flags,
	output logic done
);
	// apb state
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic [31:0] rd_word;
	logic hit;
	logic commit;
	// operation state
	fcc_op_e op_q, op_d;
	fcc_op_e last_q, last_d;
	fcc_size_e size_q, size_d;
	fcc_mode_e mode_q, mode_d;
	logic var_q, var_d;
	logic bad_q, bad_d;
	logic [FCC_MASK_W-1:0] mask_q, mask_d;
	logic [FCC_INSTR_W-1:0] instr_q, instr_d;
	logic [31:0] dst_q, dst_d;
	logic [31:0] src_q, src_d;
	// flag state
	logic [FCC_FLAGS_W-1:0] flags_q, flags_d;
	logic done_q, done_d;
	// compare results per width
	logic b_bor, b_zero, b_sign, b_ovf;
	logic w_bor, w_zero, w_sign, w_ovf;
	logic l_bor, l_zero, l_sign, l_ovf;
	logic sel_bor, sel_zero, sel_sign, sel_ovf;
	logic cmd_ok;
	fcc_size_e cmd_size;
	fcc_mode_e cmd_mode;
	logic cmd_var;
	logic [31:0] diff_chk;

	// one datapath per operand width
	fcc_cmp #(.W(FCC_BYTE_W)) u_cmp_byte (
		.dst(dst_q[FCC_BYTE_W-1:0]),
		.src(src_q[FCC_BYTE_W-1:0]),
		.borrow(b_bor),
		.zero(b_zero),
		.sign(b_sign),
		.ovf(b_ovf)
	);
	fcc_cmp #(.W(FCC_WORD_W)) u_cmp_word (
		.dst(dst_q[FCC_WORD_W-1:0]),
		.src(src_q[FCC_WORD_W-1:0]),
		.borrow(w_bor),
		.zero(w_zero),
		.sign(w_sign),
		.ovf(w_ovf)
	);
	fcc_cmp #(.W(FCC_LONG_W)) u_cmp_long (
		.dst(dst_q),
		.src(src_q),
		.borrow(l_bor),
		.zero(l_zero),
		.sign(l_sign),
		.ovf(l_ovf)
	);

	// pick the flags of the selected width
	always_comb begin
		sel_bor = 1'b0;
		sel_zero = 1'b0;
		sel_sign = 1'b0;
		sel_ovf = 1'b0;
		unique case (size_q)
			FCC_SZ_BYTE: begin
				{sel_bor, sel_zero, sel_sign, sel_ovf} = {b_bor, b_zero, b_sign, b_ovf};
			end
			FCC_SZ_WORD: begin
				{sel_bor, sel_zero, sel_sign, sel_ovf} = {w_bor, w_zero, w_sign, w_ovf};
			end
			FCC_SZ_LONG: begin
				{sel_bor, sel_zero, sel_sign, sel_ovf} = {l_bor, l_zero, l_sign, l_ovf};
			end
			default: begin
				sel_bor = 1'b0;
			end
		endcase
	end

	// register read mux and address decode
	always_comb begin
		rd_word = FCC_WORD_RST;
		hit = 1'b1;
		case (paddr)
			FCC_OFS_INSTR: rd_word[FCC_INSTR_W-1:0] = instr_q;
			FCC_OFS_FLAGS: rd_word[FCC_FLAGS_W-1:0] = flags_q;
			FCC_OFS_DST: rd_word = dst_q;
			FCC_OFS_SRC: rd_word = src_q;
			FCC_OFS_CMP: rd_word[FCC_CMD_MODE_LSB+1:0] = {mode_q, var_q, size_q};
			FCC_OFS_STATUS: rd_word[2:0] = {last_q, bad_q};
			default: hit = 1'b0;
		endcase
	end

	// apb answer: one wait state, then pready with data
	always_comb begin
		pready_d = psel & penable & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		if (pready_d) begin
			pslverr_d = ~hit;
			prdata_d = rd_word;
		end
	end
	assign commit = psel & penable & pready_q & pwrite & hit;

	// compare command fields and their legality
	always_comb begin
		cmd_size = fcc_size_e'(pwdata[FCC_CMD_SIZE_LSB+1:FCC_CMD_SIZE_LSB]);
		cmd_var = pwdata[FCC_CMD_VAR_BIT];
		cmd_mode = fcc_mode_e'(pwdata[FCC_CMD_MODE_LSB+1:FCC_CMD_MODE_LSB]);
		cmd_ok = (cmd_size == FCC_SZ_BYTE) || (cmd_size == FCC_SZ_WORD)
			|| (cmd_size == FCC_SZ_LONG);
		// register compare takes any source mode
		// immediate compare needs an indirect or extended destination
		if (cmd_var && !(cmd_mode == FCC_MD_IND || cmd_mode == FCC_MD_EXT)) begin
			cmd_ok = 1'b0;
		end
	end

	// command decode and operand registers
	always_comb begin
		op_d = FCC_OP_IDLE;
		last_d = last_q;
		size_d = size_q;
		mode_d = mode_q;
		var_d = var_q;
		bad_d = bad_q;
		mask_d = mask_q;
		instr_d = instr_q;
		dst_d = dst_q;
		src_d = src_q;
		if (op_q != FCC_OP_IDLE) begin
			last_d = op_q;
		end
		if (commit) begin
			unique case (paddr)
				FCC_OFS_INSTR: begin
					instr_d = pwdata[FCC_INSTR_W-1:0];
					if (pwdata[15:8] == FCC_INV_HI && pwdata[3:0] == FCC_INV_LO) begin
						op_d = FCC_OP_INVERT;
						mask_d = pwdata[FCC_MASK_LSB+FCC_MASK_W-1:FCC_MASK_LSB];
						bad_d = 1'b0;
					end else begin
						bad_d = 1'b1;
					end
				end
				FCC_OFS_DST: dst_d = pwdata;
				FCC_OFS_SRC: src_d = pwdata;
				FCC_OFS_CMP: begin
					if (cmd_ok) begin
						op_d = FCC_OP_CMP;
						size_d = cmd_size;
						mode_d = cmd_mode;
						var_d = cmd_var;
						bad_d = 1'b0;
					end else begin
						bad_d = 1'b1;
					end
				end
				default: begin
					bad_d = bad_q;
				end
			endcase
		end
	end

	// flag register update; compare never touches dst or src
	always_comb begin
		flags_d = flags_q;
		done_d = 1'b0;
		unique case (op_q)
			FCC_OP_IDLE: begin
				if (commit && paddr == FCC_OFS_FLAGS) begin
					flags_d = pwdata[FCC_FLAGS_W-1:0];
				end
			end
			FCC_OP_INVERT: begin
				// p/v is one bit, so either name flips the same bit
				flags_d[FCC_FLG_C:FCC_FLG_PV] = flags_q[FCC_FLG_C:FCC_FLG_PV] ^ mask_q;
				done_d = 1'b1;
			end
			FCC_OP_CMP: begin
				flags_d[FCC_FLG_C] = sel_bor;
				flags_d[FCC_FLG_Z] = sel_zero;
				flags_d[FCC_FLG_S] = sel_sign;
				flags_d[FCC_FLG_PV] = sel_ovf;
				done_d = 1'b1;
			end
			default: begin
				flags_d = flags_q;
			end
		endcase
	end

	// all state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= FCC_WORD_RST;
			op_q <= FCC_OP_IDLE;
			last_q <= FCC_OP_IDLE;
			size_q <= FCC_SZ_BYTE;
			mode_q <= FCC_MD_REG;
			var_q <= 1'b0;
			bad_q <= 1'b0;
			mask_q <= '0;
			instr_q <= FCC_INSTR_RST;
			dst_q <= FCC_WORD_RST;
			src_q <= FCC_WORD_RST;
			flags_q <= FCC_FLAGS_RST;
			done_q <= 1'b0;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			op_q <= op_d;
			last_q <= last_d;
			size_q <= size_d;
			mode_q <= mode_d;
			var_q <= var_d;
			bad_q <= bad_d;
			mask_q <= mask_d;
			instr_q <= instr_d;
			dst_q <= dst_d;
			src_q <= src_d;
			flags_q <= flags_d;
			done_q <= done_d;
		end
	end

	// outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign flags = flags_q;
	assign done = done_q;

	// reference difference for checking
	assign diff_chk = dst_q - src_q;

	property p_inv_flip;
		@(posedge pclk) disable iff (!presetn)
		op_q == FCC_OP_INVERT |=> flags_q[FCC_FLG_C:FCC_FLG_PV]
			== ($past(flags_q[FCC_FLG_C:FCC_FLG_PV]) ^ $past(mask_q));
	endproperty
	a_inv_flip: assert property (p_inv_flip) else $error("masked flags not inverted");

	property p_decode;
		@(posedge pclk) disable iff (!presetn)
		commit && paddr == FCC_OFS_INSTR && pwdata[15:8] == FCC_INV_HI
			&& pwdata[3:0] == FCC_INV_LO |=> op_q == FCC_OP_INVERT ##1 done_q;
	endproperty
	a_decode: assert property (p_decode) else $error("invert word not decoded");

	property p_low_keep;
		@(posedge pclk) disable iff (!presetn)
		op_q != FCC_OP_IDLE |=> flags_q[FCC_FLG_D:0] == $past(flags_q[FCC_FLG_D:0]);
	endproperty
	a_low_keep: assert property (p_low_keep) else $error("d or h flag disturbed");

	property p_pv_shared;
		@(posedge pclk) disable iff (!presetn)
		op_q == FCC_OP_INVERT && mask_q[0] |=> flags_q[FCC_FLG_PV] != $past(flags_q[FCC_FLG_PV]);
	endproperty
	a_pv_shared: assert property (p_pv_shared) else $error("p/v bit not flipped");

	property p_sub_byte;
		@(posedge pclk) disable iff (!presetn)
		op_q == FCC_OP_CMP && size_q == FCC_SZ_BYTE |=>
			flags_q[FCC_FLG_S] == $past(diff_chk[7]) && flags_q[FCC_FLG_Z] == ($past(diff_chk[7:0]) == '0);
	endproperty
	a_sub_byte: assert property (p_sub_byte) else $error("byte compare flags wrong");

	property p_keep_ops;
		@(posedge pclk) disable iff (!presetn)
		op_q == FCC_OP_CMP |=> dst_q == $past(dst_q) && src_q == $past(src_q) && done_q;
	endproperty
	a_keep_ops: assert property (p_keep_ops) else $error("compare altered an operand");

	property p_zero_long;
		@(posedge pclk) disable iff (!presetn)
		op_q == FCC_OP_CMP && size_q == FCC_SZ_LONG |=>
			flags_q[FCC_FLG_Z] == ($past(dst_q) == $past(src_q))
			&& flags_q[FCC_FLG_S] == $past(diff_chk[31]);
	endproperty
	a_zero_long: assert property (p_zero_long) else $error("long zero or sign wrong");

	property p_ovf_long;
		@(posedge pclk) disable iff (!presetn)
		op_q == FCC_OP_CMP && size_q == FCC_SZ_LONG |=> flags_q[FCC_FLG_PV]
			== ($past(dst_q[31]) != $past(src_q[31]) && $past(diff_chk[31]) != $past(dst_q[31]));
	endproperty
	a_ovf_long: assert property (p_ovf_long) else $error("long overflow wrong");

	property p_carry_long;
		@(posedge pclk) disable iff (!presetn)
		op_q == FCC_OP_CMP && size_q == FCC_SZ_LONG |=>
			flags_q[FCC_FLG_C] == ($past(dst_q) < $past(src_q));
	endproperty
	a_carry_long: assert property (p_carry_long) else $error("long borrow wrong");

	property p_word_sign;
		@(posedge pclk) disable iff (!presetn)
		op_q == FCC_OP_CMP && size_q == FCC_SZ_WORD |=>
			flags_q[FCC_FLG_S] == $past(diff_chk[15])
			&& flags_q[FCC_FLG_C] == ($past(dst_q[15:0]) < $past(src_q[15:0]));
	endproperty
	a_word_sign: assert property (p_word_sign) else $error("word sign or borrow wrong");

	property p_imm_mode;
		@(posedge pclk) disable iff (!presetn)
		commit && paddr == FCC_OFS_CMP && pwdata[FCC_CMD_VAR_BIT]
			&& !pwdata[FCC_CMD_MODE_LSB+1] |=> op_q == FCC_OP_IDLE && bad_q;
	endproperty
	a_imm_mode: assert property (p_imm_mode) else $error("bad immediate compare taken");

	property p_reg_mode;
		@(posedge pclk) disable iff (!presetn)
		commit && paddr == FCC_OFS_CMP && !pwdata[FCC_CMD_VAR_BIT]
			&& pwdata[1:0] != 2'h3 |=> op_q == FCC_OP_CMP ##1 done_q;
	endproperty
	a_reg_mode: assert property (p_reg_mode) else $error("register compare refused");

endmodule // fcc_top

// File: dv/fcc_tb_top.sv
`timescale 1ns/10ps
module fcc_tb_top
	import fcc_pkg::*;
;
	// design ports
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, done;
	logic [FCC_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [FCC_FLAGS_W-1:0] flags;
	// bench state
	logic [31:0] rd, err, got, fl_exp;
	int failures, n_checks;
	// masks for the invert test, all four flags, single ones and none
	logic [3:0] fl_masks [6] = '{4'hF, 4'h8, 4'h4, 4'h2, 4'h1, 4'h0};

	fcc_top dut_u (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flags(flags), .done(done)
	);

	// 20 mhz clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// counts and verdict
	task automatic results();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) failures++;
		rd = prdata;
		err = {31'h0000_0000, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// bounded wait for the completion pulse
	task automatic wait_done();
		got = 32'h0000_0000;
		for (int n = 0; n < 8 && got == 32'h0000_0000; n++) begin
			@(posedge pclk);
			if (done === 1'b1) got = 32'h0000_0001;
		end
	endtask

	// expected flags of dst minus src at the chosen width
	function automatic logic [31:0] cflags(input logic [1:0] sz, input logic [31:0] d,
		input logic [31:0] s, input logic [7:0] old);
		int w;
		logic [31:0] m, df;
		logic c, z, n, v;
		w = (sz == 2'b00) ? FCC_BYTE_W : (sz == 2'b01) ? FCC_WORD_W : FCC_LONG_W;
		m = (w == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << w) - 32'h0000_0001);
		df = (d - s) & m;
		c = (d & m) < (s & m);
		z = (df == 32'h0000_0000);
		n = df[w-1];
		v = (d[w-1] != s[w-1]) && (df[w-1] != d[w-1]);
		return {24'h00_0000, c, z, n, v, old[3:0]};
	endfunction

	// flag invert with a given mask
	task automatic inv(input logic [3:0] m);
		apb(1'b0, FCC_OFS_FLAGS, 32'h0000_0000);
		fl_exp = rd ^ {24'h00_0000, m, 4'h0};
		apb(1'b1, FCC_OFS_INSTR, {16'h0000, FCC_INV_HI, m, FCC_INV_LO});
		wait_done();
		chk(got, 32'h0000_0001);
		chk({24'h00_0000, flags}, fl_exp);
		apb(1'b0, FCC_OFS_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
	endtask

	// one compare, legal or refused
	task automatic cmp(input logic [4:0] cmd, input logic [31:0] d, input logic [31:0] s,
		input logic ok);
		apb(1'b1, FCC_OFS_DST, d);
		apb(1'b1, FCC_OFS_SRC, s);
		apb(1'b0, FCC_OFS_FLAGS, 32'h0000_0000);
		fl_exp = ok ? cflags(cmd[1:0], d, s, rd[7:0]) : rd;
		apb(1'b1, FCC_OFS_CMP, {27'h000_0000, cmd});
		wait_done();
		chk(got, {31'h0000_0000, ok});
		chk({24'h00_0000, flags}, fl_exp);
		apb(1'b0, FCC_OFS_DST, 32'h0000_0000);
		chk(rd, d);
		apb(1'b0, FCC_OFS_SRC, 32'h0000_0000);
		chk(rd, s);
		apb(1'b0, FCC_OFS_STATUS, 32'h0000_0000);
		// every refused call follows a legal compare, so last op stays compare
		chk(rd, {29'h0000_0000, 2'b10, !ok});
	endtask

	// watchdog
	initial begin
		#(4000 * 50);
		failures++;
		results();
	end

	// test sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		failures = 0;
		n_checks = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0000_0000);
			chk(rd, 32'h0000_0000);
			chk(err, 32'h0000_0000);
		end
		chk({24'h00_0000, flags}, 32'h0000_0000);
		$display("test reset ended");
		// d, h and spare bits set so any stray write shows
		apb(1'b1, FCC_OFS_FLAGS, 32'h0000_000F);
		foreach (fl_masks[i]) inv(fl_masks[i]);
		apb(1'b1, FCC_OFS_INSTR, 32'h0000_8D06);
		wait_done();
		chk(got, 32'h0000_0000);
		apb(1'b1, FCC_OFS_INSTR, 32'h0000_8C55);
		wait_done();
		chk(got, 32'h0000_0000);
		// refused word: bad set, last op still invert
		apb(1'b0, FCC_OFS_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0003);
		$display("test invert ended");
		cmp(5'b00_0_00, 32'h0000_0002, 32'h0000_0003, 1'b1);
		cmp(5'b01_0_01, 32'h0000_8000, 32'h0000_0001, 1'b1);
		cmp(5'b10_0_10, 32'h1234_5678, 32'h1234_5678, 1'b1);
		cmp(5'b11_0_00, 32'hFFFF_FF7F, 32'h0000_00FF, 1'b1);
		cmp(5'b10_1_10, 32'h8000_0000, 32'h7FFF_FFFF, 1'b1);
		cmp(5'b11_1_01, 32'h0000_FFFF, 32'h0000_0001, 1'b1);
		cmp(5'b11_1_00, 32'hABCD_0080, 32'h0000_0080, 1'b1);
		cmp(5'b00_1_00, 32'h0000_0001, 32'h0000_0002, 1'b0);
		cmp(5'b01_1_01, 32'h0000_0001, 32'h0000_0002, 1'b0);
		cmp(5'b00_0_11, 32'h0000_0001, 32'h0000_0002, 1'b0);
		$display("test compare ended");
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk(err, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		apb(1'b1, 8'hFC, 32'h0000_0001);
		chk(err, 32'h0000_0001);
		// status is read only: a write leaves it as the last refused compare left it
		apb(1'b1, FCC_OFS_STATUS, 32'h0000_0000);
		chk(err, 32'h0000_0000);
		apb(1'b0, FCC_OFS_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0005);
		$display("test unmapped ended");
		results();
	end

endmodule // fcc_tb_top
